/* File: logic/pmc_top.sv */
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module pmc_top (
  input  wire logic        hclk,             // bus and main clock
  input  wire logic        hresetn,          // async reset, active low
  input  wire logic        hsel,             // slave select
  input  wire logic [31:0] haddr,            // byte address
  input  wire logic [1:0]  htrans,           // transfer type
  input  wire logic        hwrite,           // write when high
  input  wire logic [2:0]  hsize,            // transfer size
  input  wire logic [31:0] hwdata,           // write data
  input  wire logic        hready,           // bus ready
  output logic      [31:0] hrdata,           // read data
  output logic             hreadyout,        // slave ready
  output logic             hresp,            // always okay
  input  wire logic        low_osc_clk,      // 32.768 khz oscillator pin
  input  wire logic        low_osc_stable,   // low oscillator good, pin
  input  wire logic        main_osc_stable,  // main oscillator good, pin
  input  wire logic        pll_stable,       // pll locked, pin
  input  wire logic        wait_exec,        // cpu executes wait, pulse
  input  wire logic        interrupt_req,    // interrupt pending, level
  input  wire logic        wakeup_event,     // wakeup_unit event, pulse
  input  wire logic        hcc_main_off,     // hw clock control main off
  input  wire logic        hcc_pll_off,      // hw clock control pll off
  output logic             main_osc_enable,  // main oscillator enable
  output logic             pll_enable,       // pll enable
  output logic             sys_clk_en,       // system clock running
  output logic             sys_clk_slow,     // system clock is slow clock
  output logic             sys_clk_pll,      // system clock from pll
  output logic             cpu_clk_en,       // cpu clock enable
  output logic             periph_clk_en,    // other system modules
  output logic             pll_clk_en,       // pll-clocked modules
  output logic             wakeup_clk_en,    // wakeup_unit clock
  output logic             slow_tick,        // slow clock enable pulse
  output logic             twm_tick,         // timer_watchdog_unit pulse
  output logic             aux1_tick,        // aux clock 1 pulse
  output logic             aux2_tick,        // aux clock 2 pulse
  output logic             adc_tick,         // converter clock pulse
  output logic [2:0]       power_mode        // current mode code
);
  // ==========================================================
  // pin synchronisers
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
    end else begin
      sync_a <= {low_osc_clk, pll_stable, main_osc_stable, low_osc_stable};
      sync_b <= sync_a;
    end
  end
  logic lo_ok;
  logic mo_ok;
  logic pl_ok;
  logic lo_clk;
  assign lo_ok  = sync_b[0];
  assign mo_ok  = sync_b[1];
  assign pl_ok  = sync_b[2];
  assign lo_clk = sync_b[3];
  logic lo_clk_d;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lo_clk_d <= 1'b0;
    end else begin
      lo_clk_d <= lo_clk;
    end
  end
  // ==========================================================
  // registers
  logic [7:0] slow_clock_divisor;
  logic [7:0] aux_clock_divisors;
  logic [5:0] clock_reset_control;
  logic [5:0] power_mode_control;
  logic       hcc_enable;
  pmc_pkg::pmc_mode_t mode;
  // ==========================================================
  // ahb-lite slave: writes in data phase, reads take one wait state
  logic        dp_valid;
  logic        dp_write;
  logic [31:0] dp_addr;
  logic        rd_wait;
  logic        addr_ok;

  function automatic logic hit(input logic [31:0] a, input logic [23:0] idx);
    hit = (a[31:26] == 6'h00) && (a[25:2] == idx) && (a[1:0] == 2'b00);
  endfunction : hit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr  <= 32'h0;
    end else if (hready) begin
      dp_valid <= hsel && htrans[1];
      dp_write <= hwrite;
      dp_addr  <= haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_wait <= 1'b0;
    end else begin
      rd_wait <= dp_valid && !dp_write && !rd_wait;
    end
  end
  assign hreadyout = !(dp_valid && !dp_write && !rd_wait);
  assign hresp     = 1'b0;
  assign addr_ok   = hsize == 3'b010;
  logic wr_en;
  logic [7:0] wd;
  assign wr_en = dp_valid && dp_write;
  assign wd    = hwdata[7:0];
  logic wr_crc;
  logic wr_sdiv;
  logic wr_adiv;
  logic wr_pmc;
  logic wr_hcc;
  assign wr_crc  = wr_en && hit(dp_addr, pmc_pkg::IDX_CLOCK_RESET_CONTROL);
  assign wr_sdiv = wr_en && hit(dp_addr, pmc_pkg::IDX_SLOW_CLOCK_DIVISOR);
  assign wr_adiv = wr_en && hit(dp_addr, pmc_pkg::IDX_AUX_CLOCK_DIVISORS);
  assign wr_pmc  = wr_en && hit(dp_addr, pmc_pkg::IDX_POWER_MODE_CONTROL);
  assign wr_hcc  = wr_en && hit(dp_addr, pmc_pkg::IDX_HW_CLOCK_CONTROL);
  logic [7:0] status;
  assign status = {5'h00, (pl_ok || !pll_enable), mo_ok, lo_ok};
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    if (hit(dp_addr, pmc_pkg::IDX_CLOCK_RESET_CONTROL)) begin
      next_rdata = {2'b00, clock_reset_control};
    end else if (hit(dp_addr, pmc_pkg::IDX_SLOW_CLOCK_DIVISOR)) begin
      next_rdata = slow_clock_divisor;
    end else if (hit(dp_addr, pmc_pkg::IDX_AUX_CLOCK_DIVISORS)) begin
      next_rdata = aux_clock_divisors;
    end else if (hit(dp_addr, pmc_pkg::IDX_POWER_MODE_CONTROL)) begin
      next_rdata = {2'b00, power_mode_control};
    end else if (hit(dp_addr, pmc_pkg::IDX_POWER_MODE_STATUS)) begin
      next_rdata = status;
    end else if (hit(dp_addr, pmc_pkg::IDX_HW_CLOCK_CONTROL)) begin
      next_rdata = {7'h00, hcc_enable};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (dp_valid && !dp_write && !rd_wait) begin
      hrdata <= {24'h000000, next_rdata};
    end
  end

  // ==========================================================
  // divisor and clock control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slow_clock_divisor <= pmc_pkg::SLOW_DIV_RESET;
      aux_clock_divisors <= pmc_pkg::AUX_DIV_RESET;
      hcc_enable         <= 1'b0;
    end else begin
      if (wr_sdiv) begin
        slow_clock_divisor <= wd;
      end
      if (wr_adiv) begin
        aux_clock_divisors <= wd;
      end
      if (wr_hcc) begin
        hcc_enable <= wd[0];
      end
    end
  end

  // fclk may only leave main clock with pll up and stable; pll_power_down
  // may only be set while main clock is the source
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clock_reset_control <= pmc_pkg::CRC_RESET;
    end else if (wr_crc) begin
      clock_reset_control[pmc_pkg::CRC_SCLK] <= wd[pmc_pkg::CRC_SCLK];
      clock_reset_control[pmc_pkg::CRC_ACE1] <= wd[pmc_pkg::CRC_ACE1];
      clock_reset_control[pmc_pkg::CRC_ACE2] <= wd[pmc_pkg::CRC_ACE2];
      if (wd[pmc_pkg::CRC_FCLK] || (!clock_reset_control[pmc_pkg::CRC_PLL_POWER_DOWN] && pl_ok)) begin
        clock_reset_control[pmc_pkg::CRC_FCLK] <= wd[pmc_pkg::CRC_FCLK];
      end
      if (!wd[pmc_pkg::CRC_PLL_POWER_DOWN] || clock_reset_control[pmc_pkg::CRC_FCLK]) begin
        clock_reset_control[pmc_pkg::CRC_PLL_POWER_DOWN] <= wd[pmc_pkg::CRC_PLL_POWER_DOWN];
      end
      if (!wd[pmc_pkg::CRC_POR]) begin
        clock_reset_control[pmc_pkg::CRC_POR] <= 1'b0;
      end
    end
  end
  logic sclk_low;
  logic pll_power_down;
  assign sclk_low = clock_reset_control[pmc_pkg::CRC_SCLK];
  assign pll_power_down   = clock_reset_control[pmc_pkg::CRC_PLL_POWER_DOWN];

  // ==========================================================
  // power manager
  logic wait_before_power_save;
  logic main_osc_disable;
  logic pll_lowpower_disable;
  assign wait_before_power_save = power_mode_control[pmc_pkg::PMC_WAIT_BEFORE_POWER_SAVE];
  assign main_osc_disable   = power_mode_control[pmc_pkg::PMC_DMC];
  assign pll_lowpower_disable   = power_mode_control[pmc_pkg::PMC_DHC];
  logic [2:0] req_bits;
  assign req_bits = power_mode_control[2:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode               <= pmc_pkg::MODE_ACTIVE;
      power_mode_control <= 6'h00;
    end else begin
      case (mode)
        pmc_pkg::MODE_ACTIVE: begin
          if (wr_pmc) begin
            power_mode_control[pmc_pkg::PMC_WAIT_BEFORE_POWER_SAVE] <= wd[pmc_pkg::PMC_WAIT_BEFORE_POWER_SAVE];
            power_mode_control[pmc_pkg::PMC_DMC]   <= wd[pmc_pkg::PMC_DMC];
            power_mode_control[pmc_pkg::PMC_DHC]   <= wd[pmc_pkg::PMC_DHC];
            if (lo_ok) begin
              if (wd[pmc_pkg::PMC_WAIT_BEFORE_POWER_SAVE]) begin
                power_mode_control[2:0] <= wd[2:0];
              end else if (wd[pmc_pkg::PMC_PSM]) begin
                power_mode_control[pmc_pkg::PMC_PSM] <= 1'b1;
                mode <= pmc_pkg::MODE_PSAVE;
              end
            end
          end else if (wakeup_event) begin
            power_mode_control[2:0] <= 3'b000;
          end else if (wait_exec && wait_before_power_save && lo_ok) begin
            if (req_bits[pmc_pkg::PMC_HALT]) begin
              mode <= pmc_pkg::MODE_HALT;
            end else if (req_bits[pmc_pkg::PMC_IDLE]) begin
              mode <= pmc_pkg::MODE_IDLE;
            end else if (req_bits[pmc_pkg::PMC_PSM]) begin
              mode <= pmc_pkg::MODE_PSAVE;
            end
          end
        end
        pmc_pkg::MODE_PSAVE, pmc_pkg::MODE_IDLE: begin
          if (wakeup_event) begin
            power_mode_control[2:0]              <= 3'b000;
            power_mode_control[pmc_pkg::PMC_DMC] <= 1'b0;
            power_mode_control[pmc_pkg::PMC_DHC] <= 1'b0;
          end else if (wr_pmc) begin
            power_mode_control <= wd[5:0];
          end
          // leave only once the main oscillator is back
          if (power_mode_control[2:0] == 3'b000 && mo_ok) begin
            mode <= pmc_pkg::MODE_ACTIVE;
          end
        end
        pmc_pkg::MODE_HALT: begin
          if (wakeup_event) begin
            power_mode_control[pmc_pkg::PMC_DMC] <= 1'b0;
            power_mode_control[pmc_pkg::PMC_DHC] <= 1'b0;
            mode <= pmc_pkg::MODE_HALT_EXIT;
          end else if (wr_pmc) begin
            power_mode_control <= wd[5:0];
          end
        end
        pmc_pkg::MODE_HALT_EXIT: begin
          if (mo_ok) begin
            power_mode_control[2:0] <= 3'b000;
            mode <= pmc_pkg::MODE_ACTIVE;
          end
        end
        default: begin
          mode <= pmc_pkg::MODE_ACTIVE;
        end
      endcase
    end
  end
  assign power_mode = mode;
  logic low_mode;
  logic in_halt;
  assign low_mode = (mode == pmc_pkg::MODE_PSAVE) || (mode == pmc_pkg::MODE_IDLE);
  assign in_halt  = (mode == pmc_pkg::MODE_HALT);

  // ==========================================================
  // oscillator and pll control
  // in power save and idle a disable bit (main only with sclk low) or hardware control switches off; forced in active and halt
  always_comb begin
    main_osc_enable = 1'b1;
    pll_enable      = !pll_power_down;
    if (in_halt) begin
      main_osc_enable = 1'b0;
      pll_enable      = 1'b0;
    end else if (low_mode) begin
      if ((main_osc_disable && sclk_low) || (hcc_enable && hcc_main_off)) begin
        main_osc_enable = 1'b0;
      end
      if (pll_lowpower_disable || (hcc_enable && hcc_pll_off) || pll_power_down) begin
        pll_enable = 1'b0;
      end
    end
  end
  logic main_run;
  assign main_run = main_osc_enable && mo_ok;
  // ==========================================================
  // cpu wait stall
  logic cpu_stall;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_stall <= 1'b0;
    end else if (wait_exec) begin
      cpu_stall <= 1'b1;
    end else if (interrupt_req) begin
      cpu_stall <= 1'b0;
    end
  end

  // ==========================================================
  // slow prescaler: period reloads at its end so no runt pulse
  logic [8:0] slow_cnt;
  logic       pre_tick;
  assign pre_tick = main_run && (slow_cnt == 9'h000);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slow_cnt <= {pmc_pkg::SLOW_DIV_RESET, 1'b1};
    end else if (main_run) begin
      if (slow_cnt == 9'h000) begin
        slow_cnt <= {slow_clock_divisor, 1'b1};
      end else begin
        slow_cnt <= slow_cnt - 9'h001;
      end
    end
  end
  logic slow_raw;
  assign slow_raw = sclk_low ? (lo_clk && !lo_clk_d) : pre_tick;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slow_tick <= 1'b0;
      twm_tick  <= 1'b0;
    end else begin
      slow_tick <= slow_raw && !in_halt;
      twm_tick  <= slow_raw && !in_halt;
    end
  end
  // ==========================================================
  // aux prescalers
  logic [1:0] aux_en;
  logic [1:0] aux_hit;
  assign aux_en = {clock_reset_control[pmc_pkg::CRC_ACE2] && main_run,
                   clock_reset_control[pmc_pkg::CRC_ACE1] && main_run};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_aux
      logic [pmc_pkg::AUX_W-1:0] cnt;
      logic [pmc_pkg::AUX_W-1:0] div;
      assign div        = aux_clock_divisors[gi*pmc_pkg::AUX_W +: pmc_pkg::AUX_W];
      assign aux_hit[gi] = aux_en[gi] && (cnt == '0);
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cnt <= '1;
        end else if (aux_en[gi]) begin
          if (cnt == '0) begin
            cnt <= div;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aux1_tick <= 1'b0;
      aux2_tick <= 1'b0;
      adc_tick  <= 1'b0;
    end else begin
      aux1_tick <= aux_hit[0];
      aux2_tick <= aux_hit[1];
      adc_tick  <= aux_hit[1];
    end
  end

  // ==========================================================
  // module clock gating
  always_comb begin
    sys_clk_en    = (mode == pmc_pkg::MODE_ACTIVE) || (mode == pmc_pkg::MODE_PSAVE);
    sys_clk_slow  = (mode == pmc_pkg::MODE_PSAVE);
    sys_clk_pll   = (mode == pmc_pkg::MODE_ACTIVE)
                    && !clock_reset_control[pmc_pkg::CRC_FCLK];
    cpu_clk_en    = sys_clk_en && !cpu_stall;
    periph_clk_en = sys_clk_en;
    pll_clk_en    = pll_enable && pl_ok && !in_halt;
    wakeup_clk_en = sys_clk_en;
  end
  logic unused_ok;
  assign unused_ok = addr_ok;
endmodule : pmc_top
`default_nettype wire

/* File: logic/pmc_pkg.sv */
package pmc_pkg;
  // ==========================================================
  // register indexes (byte address is four times the index)
  localparam logic [23:0] IDX_CLOCK_RESET_CONTROL = 24'hfffc40;
  localparam logic [23:0] IDX_SLOW_CLOCK_DIVISOR  = 24'hfffc44;
  localparam logic [23:0] IDX_AUX_CLOCK_DIVISORS  = 24'hfffc46;
  localparam logic [23:0] IDX_POWER_MODE_CONTROL  = 24'hfffc60;
  localparam logic [23:0] IDX_POWER_MODE_STATUS   = 24'hfffc62;
  localparam logic [23:0] IDX_HW_CLOCK_CONTROL    = 24'hfffc64;
  // ==========================================================
  // reset values
  localparam logic [7:0] SLOW_DIV_RESET = 8'hb6;
  localparam logic [7:0] AUX_DIV_RESET  = 8'hff;
  // ==========================================================
  // clock_reset_control fields
  localparam int CRC_SCLK   = 0;
  localparam int CRC_FCLK   = 1;
  localparam int CRC_PLL_POWER_DOWN = 2;
  localparam int CRC_ACE1   = 3;
  localparam int CRC_ACE2   = 4;
  localparam int CRC_POR    = 5;
  localparam logic [5:0] CRC_RESET = 6'h26;
  // ==========================================================
  // power_mode_control fields
  localparam int PMC_PSM   = 0;
  localparam int PMC_IDLE  = 1;
  localparam int PMC_HALT  = 2;
  localparam int PMC_WAIT_BEFORE_POWER_SAVE = 3;
  localparam int PMC_DMC   = 4;
  localparam int PMC_DHC   = 5;
  // power_mode_status fields
  localparam int PMS_OLC = 0;
  localparam int PMS_OMC = 1;
  localparam int PMS_OHC = 2;
  // aux divisor field positions
  localparam int AUX1_LSB = 0;
  localparam int AUX2_LSB = 4;
  localparam int AUX_W    = 4;
  // ==========================================================
  typedef enum logic [2:0] {
    MODE_ACTIVE,
    MODE_PSAVE,
    MODE_IDLE,
    MODE_HALT,
    MODE_HALT_EXIT
  } pmc_mode_t;
endpackage : pmc_pkg

/* File: tb/pmc_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module pmc_chk (
  input wire logic       hclk,            // clock
  input wire logic       hresetn,         // reset
  input wire logic       hsel,            // select
  input wire logic [1:0] htrans,          // transfer
  input wire logic       hwrite,          // write
  input wire logic       hready,          // bus ready
  input wire logic       hreadyout,       // slave ready
  input wire logic       low_osc_stable,  // low osc ok
  input wire logic       main_osc_enable, // main osc on
  input wire logic       pll_enable,      // pll on
  input wire logic       sys_clk_en,      // sys clock
  input wire logic       sys_clk_slow,    // sys slow
  input wire logic       cpu_clk_en,      // cpu clock
  input wire logic       periph_clk_en,   // periph clock
  input wire logic       pll_clk_en,      // pll modules
  input wire logic       wakeup_clk_en,   // wakeup clock
  input wire logic       slow_tick,       // slow pulse
  input wire logic       twm_tick,        // timer pulse
  input wire logic       aux1_tick,       // aux1 pulse
  input wire logic       aux2_tick,       // aux2 pulse
  input wire logic       adc_tick,        // adc pulse
  input wire logic [2:0] power_mode       // mode
);
  // ==========================================================
  // mode and bus checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd_addr;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  // one cycle of margin: ticks are registered
  sequence in_halt;
    power_mode == 3'h3 && $past(power_mode) == 3'h3;
  endsequence
  read_wait_a: assert property (rd_addr |=> !hreadyout ##1 hreadyout)
    else $error("read data phase timing wrong");
  halt_osc_a: assert property (power_mode == 3'h3 |-> !main_osc_enable && !pll_enable)
    else $error("oscillator or pll on in halt");
  active_osc_a: assert property (power_mode == 3'h0 |-> main_osc_enable)
    else $error("main oscillator off in active");
  psave_clk_a: assert property (power_mode == 3'h1 |-> sys_clk_en && sys_clk_slow)
    else $error("power save not on slow clock");
  idle_clk_a: assert property (power_mode == 3'h2 |-> !sys_clk_en && !cpu_clk_en && !periph_clk_en)
    else $error("system clock runs in idle");
  halt_clk_a: assert property (power_mode == 3'h3 |-> !sys_clk_en && !cpu_clk_en && !pll_clk_en)
    else $error("clocks run in halt");
  halt_tick_a: assert property (in_halt |-> !slow_tick && !twm_tick)
    else $error("slow tick in halt");
  // main stable is synchronised, so allow it to drain
  aux_halt_a: assert property (power_mode == 3'h3 && $past(power_mode, 4) == 3'h3
    |-> !aux1_tick && !aux2_tick && !adc_tick)
    else $error("aux tick without main clock");
  // wake-up logic keeps working while its clock is suspended
  wakeup_clk_a: assert property (wakeup_clk_en == (power_mode < 3'h2))
    else $error("wakeup clock gating wrong");
  low_refuse_a: assert property (!low_osc_stable [*3] ##1 power_mode == 3'h0
    |=> power_mode == 3'h0)
    else $error("low power entry without low osc");
endmodule : pmc_chk
bind pmc_top pmc_chk pmc_chk_i (.*);
`default_nettype wire

/* File: tb/pmc_osc_model.sv */
`timescale 1ns/10ps
`default_nettype none
module pmc_osc_model (
  input  wire logic hclk,            // main clock
  input  wire logic main_osc_enable, // start main osc
  input  wire logic pll_enable,      // start pll
  input  wire logic low_ok,          // low osc health
  output var logic  low_osc_clk,     // 32k stand-in
  output var logic  low_osc_stable,  // low osc good
  output var logic  main_osc_stable, // main osc good
  output var logic  pll_stable       // pll locked
);
  // ==========================================================
  // start-up delay after enable; stable drops at once
  logic [3:0] low_cnt = 4'h0;
  logic [3:0] main_cnt = 4'h0;
  logic [3:0] pll_cnt = 4'h0;
  initial low_osc_clk = 1'b0;
  always @(posedge hclk) begin
    low_cnt <= low_cnt + 4'h1;
    if (low_cnt == 4'hf) begin
      low_osc_clk <= ~low_osc_clk;
    end
    main_cnt <= !main_osc_enable ? 4'h0 : (main_cnt == 4'hf ? main_cnt : main_cnt + 4'h1);
    pll_cnt <= !pll_enable ? 4'h0 : (pll_cnt == 4'hf ? pll_cnt : pll_cnt + 4'h1);
  end
  assign low_osc_stable  = low_ok;
  assign main_osc_stable = main_cnt == 4'hf;
  assign pll_stable      = pll_cnt == 4'hf;
endmodule : pmc_osc_model
`default_nettype wire

/* File: tb/pmc_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module pmc_top_tb;
  typedef struct packed {logic [23:0] idx; logic wr; logic [7:0] d; logic [7:0] exp;} pmc_row_t;
  logic        hclk, hresetn, hsel, hwrite, low_ok, wait_exec, interrupt_req, wakeup_event;
  logic [1:0]  htrans;
  logic [2:0]  hsize, power_mode;
  logic [31:0] haddr, hwdata, hrdata;
  logic        hreadyout, hresp, low_osc_clk, low_osc_stable, main_osc_stable, pll_stable;
  logic        main_osc_enable, pll_enable, sys_clk_en, sys_clk_slow, sys_clk_pll, cpu_clk_en;
  logic        periph_clk_en, pll_clk_en, wakeup_clk_en, slow_tick, twm_tick, aux1_tick;
  logic        aux2_tick, adc_tick, hcc_off;
  logic [7:0]  q;
  int          n, fails, samples_checked;
  wire  [3:0]  ticks;
  assign ticks = {adc_tick, aux2_tick, aux1_tick, slow_tick};
  pmc_row_t rows [11] = '{
    '{pmc_pkg::IDX_SLOW_CLOCK_DIVISOR, 1'b0, 8'h00, 8'hb6},
    '{pmc_pkg::IDX_AUX_CLOCK_DIVISORS, 1'b0, 8'h00, 8'hff},
    '{pmc_pkg::IDX_POWER_MODE_CONTROL, 1'b0, 8'h00, 8'h00},
    '{pmc_pkg::IDX_SLOW_CLOCK_DIVISOR, 1'b1, 8'h03, 8'h00},
    '{pmc_pkg::IDX_SLOW_CLOCK_DIVISOR, 1'b0, 8'h00, 8'h03},
    '{pmc_pkg::IDX_AUX_CLOCK_DIVISORS, 1'b1, 8'h21, 8'h00},
    '{pmc_pkg::IDX_AUX_CLOCK_DIVISORS, 1'b0, 8'h00, 8'h21},
    '{24'hfffc50, 1'b1, 8'h5a, 8'h00},
    '{24'hfffc50, 1'b0, 8'h00, 8'h00},
    '{pmc_pkg::IDX_CLOCK_RESET_CONTROL, 1'b1, 8'h3e, 8'h00},
    '{pmc_pkg::IDX_CLOCK_RESET_CONTROL, 1'b0, 8'h00, 8'h3e}};
  pmc_top pmc_top_i (.hready(hreadyout), .hcc_main_off(hcc_off), .hcc_pll_off(hcc_off), .*);
  pmc_osc_model pmc_osc_model_i (.*);
  always #10 hclk = ~hclk;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // ==========================================================
  // single word transfer, waits on hready in both phases
  task automatic bus(input logic [23:0] idx, input logic wr, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {6'h00, idx, 2'b00};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h000000, d};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata[7:0];
  endtask : bus
  task automatic period(input int sel);
    n = 0;
    @(posedge hclk);
    while (ticks[sel] !== 1'b1) @(posedge hclk);
    do begin
      @(posedge hclk);
      n++;
    end while (ticks[sel] !== 1'b1);
  endtask : period
  task automatic wait_mode(input logic [2:0] m);
    for (int k = 0; k < 300 && power_mode !== m; k++) @(posedge hclk);
    check({5'h00, power_mode}, {5'h00, m});
  endtask : wait_mode
  // w high: cpu wait; low: wakeup with its interrupt
  task automatic pulse(input logic w);
    wait_exec <= w;
    wakeup_event <= !w;
    interrupt_req <= !w;
    @(posedge hclk);
    wait_exec <= 1'b0;
    wakeup_event <= 1'b0;
    interrupt_req <= 1'b0;
  endtask : pulse
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report
  initial begin
    #(20 * 20000);
    fails++;
    final_report();
  end
  initial begin
    {hclk, hresetn, hsel, hwrite, wait_exec, interrupt_req, wakeup_event, hcc_off} = 8'h00;
    {htrans, haddr, hwdata, fails, samples_checked} = '0;
    hsize = 3'b010;
    low_ok = 1'b1;
    repeat (4) @(posedge hclk);
    check({5'h00, power_mode}, 8'h00);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    foreach (rows[i]) begin
      bus(rows[i].idx, rows[i].wr, rows[i].d);
      if (!rows[i].wr) check(q, rows[i].exp);
    end
    check({6'h00, hresp, sys_clk_pll}, 8'h00);
    period(0);
    check(n[7:0], 8'h08);
    period(1);
    check(n[7:0], 8'h02);
    period(2);
    check(n[7:0], 8'h03);
    period(3);
    check(n[7:0], 8'h03);
    bus(pmc_pkg::IDX_POWER_MODE_CONTROL, 1'b1, 8'h01);
    wait_mode(3'h1);
    bus(pmc_pkg::IDX_POWER_MODE_CONTROL, 1'b1, 8'h00);
    wait_mode(3'h0);
    bus(pmc_pkg::IDX_POWER_MODE_CONTROL, 1'b1, 8'h0a);
    check({5'h00, power_mode}, 8'h00);
    pulse(1'b1);
    wait_mode(3'h2);
    pulse(1'b0);
    wait_mode(3'h0);
    bus(pmc_pkg::IDX_POWER_MODE_CONTROL, 1'b1, 8'h0c);
    pulse(1'b1);
    wait_mode(3'h3);
    repeat (40) @(posedge hclk);
    pulse(1'b0);
    wait_mode(3'h0);
    bus(pmc_pkg::IDX_POWER_MODE_CONTROL, 1'b0, 8'h00);
    check(q & 8'h04, 8'h00);
    // slow clock from the low oscillator, then hardware and software main-off
    bus(pmc_pkg::IDX_CLOCK_RESET_CONTROL, 1'b1, 8'h3f);
    period(0);
    check(n[7:0], 8'h20);
    bus(pmc_pkg::IDX_HW_CLOCK_CONTROL, 1'b1, 8'h01);
    hcc_off <= 1'b1;
    bus(pmc_pkg::IDX_POWER_MODE_CONTROL, 1'b1, 8'h01);
    check({7'h00, main_osc_enable}, 8'h01);
    wait_mode(3'h1);
    check({7'h00, main_osc_enable}, 8'h00);
    hcc_off <= 1'b0;
    bus(pmc_pkg::IDX_POWER_MODE_CONTROL, 1'b1, 8'h11);
    repeat (2) @(posedge hclk);
    check({7'h00, main_osc_enable}, 8'h00);
    bus(pmc_pkg::IDX_POWER_MODE_CONTROL, 1'b1, 8'h00);
    wait_mode(3'h0);
    pulse(1'b1);
    @(posedge hclk);
    check({7'h00, cpu_clk_en}, 8'h00);
    pulse(1'b0);
    @(posedge hclk);
    check({7'h00, cpu_clk_en}, 8'h01);
    low_ok <= 1'b0;
    repeat (4) @(posedge hclk);
    bus(pmc_pkg::IDX_POWER_MODE_CONTROL, 1'b1, 8'h01);
    repeat (4) @(posedge hclk);
    check({5'h00, power_mode}, 8'h00);
    hresetn <= 1'b0;
    low_ok <= 1'b1;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(pmc_pkg::IDX_SLOW_CLOCK_DIVISOR, 1'b0, 8'h00);
    check(q, 8'hb6);
    final_report();
  end
endmodule : pmc_top_tb
`default_nettype wire
